/* File: rtl/atacpi_params.svh */
// Constants of the ATA command and PIO interface
// Assumes inclusion by the core only
`ifndef ATACPI_PARAMS_SVH
`define ATACPI_PARAMS_SVH

// ----------------------------------------------------------------
// Host register addresses, DA(2:0)
// ----------------------------------------------------------------
`define ATACPI_A_DATA     3'h0
`define ATACPI_A_FEAT     3'h1
`define ATACPI_A_SCNT     3'h2
`define ATACPI_A_SNUM     3'h3
`define ATACPI_A_CYLL     3'h4
`define ATACPI_A_CYLH     3'h5
`define ATACPI_A_DEVH     3'h6
`define ATACPI_A_CMD      3'h7
`define ATACPI_A_DEVCTL   3'h6

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define ATACPI_B_DEV      4
`define ATACPI_B_SRST     2
`define ATACPI_B_NIEN     1
`define ATACPI_B_MCR      3
`define ATACPI_B_ABRT     2

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define ATACPI_C_PWR      8'he5
`define ATACPI_C_LOCK     8'hde
`define ATACPI_C_UNLOCK   8'hdf
`define ATACPI_C_EJECT    8'hed
`define ATACPI_C_DIAG     8'h90
`define ATACPI_C_IDENT    8'hec
`define ATACPI_C_RDMUL    8'hc4
`define ATACPI_C_WRMUL    8'hc5

// ----------------------------------------------------------------
// Result and reset values
// ----------------------------------------------------------------
`define ATACPI_SC_STANDBY 8'h00
`define ATACPI_SC_IDLE    8'hff
`define ATACPI_ERR_DIAG   8'h01
`define ATACPI_RST_CTRL   2'h0

// ----------------------------------------------------------------
// Avalon register byte offsets and fields
// ----------------------------------------------------------------
`define ATACPI_R_CTRL     5'h00
`define ATACPI_R_ISTAT    5'h04
`define ATACPI_R_IMASK    5'h08
`define ATACPI_R_CMD      5'h0c
`define ATACPI_R_DONE     5'h10
`define ATACPI_R_DATA     5'h14
`define ATACPI_B_DRQ      8
`define ATACPI_B_DOUT     9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ATACPI_CLK_NS     25
`define ATACPI_MINCYC_NS  120
`define ATACPI_TRD_NS     5

`endif

/* File: rtl/atacpi_pkg.sv */
// Types of the ATA command and PIO interface
// Assumes the constants header sits beside it
package atacpi_pkg;
   typedef enum logic [3:0] {
      OP_NOP, OP_PWR, OP_LOCK, OP_UNLOCK, OP_EJECT, OP_DIAG, OP_IDENT,
      OP_RDMUL, OP_WRMUL, OP_READ, OP_WRITE, OP_REASGN, OP_OTHER, OP_BAD
   } atacpi_op_t;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FW} atacpi_st_t;
endpackage

/* File: rtl/atacpi_sync.sv */
// Three-stage input synchroniser with agreement filter
// Assumes asynchronous inputs and one clock domain
`timescale 1ns/1ps
module atacpi_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
)(
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   // Data
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;
   wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
   wire  [W-1:0] nxt_q = (agree & s3_ff) | (~agree & q_ff);

   if (W < 1) begin : g_chk
      $error("atacpi_sync: width must be positive");
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_ff <= RST;
         s2_ff <= RST;
         s3_ff <= RST;
         q_ff  <= RST;
      end else begin
         s1_ff <= i_d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= nxt_q;
      end
   end
   assign o_q = q_ff;
endmodule

/* File: rtl/atacpi_core.sv */
// Device-side ATA command interpreter and PIO register port
// Assumes host strobes on pins and firmware on Avalon-MM
//
// Overview of operation
// - Serve PIO and register cycles at 120 ns
// - Data register 16 bits, command registers 8
// - Device lengthens cycles by dropping IORDY
// - IORDY kept high when data ready
// - Hold IORDY low; drive data tRD first
// - Decode every supported command code
// - Status register valid at every completion
// - Power query E5h ignores other inputs
// - Power query returns 00h standby, FFh idle
// - Good completion: BSY low, DRDY high, ERR low
// - Error completion sets ERR, DRDY; clears DRQ
// - Lock: lock; error too if already locked and button active
// - Unlock, eject, reset clear lock; button flagged
// - Error bit 3 removal request, bit 2 abort
// - Status read clears pending host interrupt
`timescale 1ns/1ps
`include "atacpi_params.svh"
module atacpi_core
   import atacpi_pkg::*;
#(
   parameter logic P_DEV    = 1'b0,
   parameter int   P_TRD_NS = `ATACPI_TRD_NS
)(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // Host ATA port
   input  wire logic        i_cs0_n,
   input  wire logic        i_cs1_n,
   input  wire logic [2:0]  i_da,
   input  wire logic        i_dior_n,
   input  wire logic        i_diow_n,
   input  wire logic [15:0] i_dd,
   output logic      [15:0] o_dd,
   output logic             o_dd_oe,
   output logic             o_iordy,
   output logic             o_intrq,
   // Drive mechanics
   input  wire logic        i_media_change_requested,
   // Avalon-MM slave
   input  wire logic [4:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   output logic             o_irq
);
   // ----------------------------------------------------------------
   // Timing constants
   // ----------------------------------------------------------------
   localparam int TRD_RAW = (P_TRD_NS + `ATACPI_CLK_NS - 1) / `ATACPI_CLK_NS;
   localparam int TRD_CLK = (TRD_RAW < 1) ? 1 : TRD_RAW;
   localparam int MINCYC_CLK = `ATACPI_MINCYC_NS / `ATACPI_CLK_NS;
   // extra clock lets DD lead IORDY
   localparam logic [3:0] TRD_CNT = 4'(TRD_CLK + 1);

   // strobe pulses must fit the filter
   if (MINCYC_CLK < 4 || TRD_CLK > 14) begin : g_chk
      $error("atacpi_core: clock too slow for 120 ns cycles");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [7:0]  ctl_q;
   logic [15:0] dd_q;
   atacpi_sync #(.W(8), .RST(8'hff)) u_sync_ctl (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_d    ({i_cs0_n, i_cs1_n, i_da, i_dior_n, i_diow_n,
                ~i_media_change_requested}),
      .o_q    (ctl_q)
   );
   atacpi_sync #(.W(16), .RST(16'h0000)) u_sync_dd (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_d    (i_dd),
      .o_q    (dd_q)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   atacpi_st_t  st_ff;
   atacpi_op_t  op_ff;
   logic [4:0]  adr_ff;
   logic [15:0] dd_ff;
   logic [1:0]  strb_ff;
   logic        btn_ff;
   logic [7:0]  feat_ff, scnt_ff, snum_ff, cyll_ff, cylh_ff, devh_ff;
   logic [7:0]  cmd_ff, err_reg_ff;
   logic        err_ff, drq_ff, dout_ff, drdy_ff, pend_ff;
   logic        srst_ff, nien_ff, locked_ff, mcr_seen_ff;
   logic [15:0] word_ff, host_word_ff;
   logic        word_vld_ff, hw_vld_ff;
   logic [3:0]  trd_ff;
   logic [1:0]  ctrl_ff;
   logic [3:0]  istat_ff, imask_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic [15:0] dd_out_ff;

   // ----------------------------------------------------------------
   // Host cycle decode
   // ----------------------------------------------------------------
   wire        btn_q    = ~ctl_q[0];
   wire        dior_n_q = ctl_q[2];
   wire        diow_n_q = ctl_q[1];
   wire        rd_end   = ~strb_ff[1] & dior_n_q;
   wire        wr_end   = ~strb_ff[0] & diow_n_q;
   wire [2:0]  da       = adr_ff[2:0];
   wire        cmdblk   = ~adr_ff[4] & adr_ff[3];
   wire        ctlblk   = adr_ff[4] & ~adr_ff[3];
   wire        dev_sel  = devh_ff[`ATACPI_B_DEV] == P_DEV;
   wire        bsy      = (st_ff != ST_IDLE) | srst_ff;
   wire        wr_ok    = wr_end & cmdblk & ~bsy;
   wire        sel_data = cmdblk & (da == `ATACPI_A_DATA);
   wire        sel_cmd  = cmdblk & (da == `ATACPI_A_CMD);
   wire        sel_ctl  = ctlblk & (da == `ATACPI_A_DEVCTL);
   wire        cmd_go   = wr_ok & sel_cmd & dev_sel & ~drq_ff;
   wire        dctl_wr  = wr_end & sel_ctl;
   wire        sts_rd   = rd_end & sel_cmd & dev_sel;
   wire        data_wr  = wr_end & sel_data & drq_ff & dout_ff;
   wire        data_rd  = rd_end & sel_data & drq_ff & ~dout_ff;
   wire        btn_rise = btn_q & ~btn_ff;
   wire [7:0]  status   = {bsy, drdy_ff, ctrl_ff[1], 1'b0,
                           drq_ff, 2'b00, err_ff};

   function automatic atacpi_op_t f_decode(input logic [7:0] c);
      case (c)
         8'h00:           f_decode = OP_NOP;
         `ATACPI_C_PWR:   f_decode = OP_PWR;
         `ATACPI_C_LOCK:  f_decode = OP_LOCK;
         `ATACPI_C_UNLOCK:f_decode = OP_UNLOCK;
         `ATACPI_C_EJECT: f_decode = OP_EJECT;
         `ATACPI_C_DIAG:  f_decode = OP_DIAG;
         `ATACPI_C_IDENT: f_decode = OP_IDENT;
         `ATACPI_C_RDMUL: f_decode = OP_RDMUL;
         `ATACPI_C_WRMUL: f_decode = OP_WRMUL;
         8'h20, 8'h21:    f_decode = OP_READ;
         8'h30, 8'h31:    f_decode = OP_WRITE;
         8'hf8, 8'hfb, 8'hfc: f_decode = OP_REASGN;
         8'h92, 8'h91, 8'he3, 8'he1, 8'hda, 8'h40, 8'h41, 8'h70,
         8'hef, 8'hc6, 8'he6, 8'he2, 8'he0, 8'hf0, 8'hc0:
                          f_decode = OP_OTHER;
         default:         f_decode = OP_BAD;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Command execution
   // ----------------------------------------------------------------
   wire hw_op   = (op_ff == OP_PWR) | (op_ff == OP_LOCK) |
                  (op_ff == OP_UNLOCK) | (op_ff == OP_BAD);
   wire in_exec = (st_ff == ST_EXEC) & ~srst_ff;
   wire mcr_hit = btn_q | mcr_seen_ff;

   // Avalon decode
   wire        avs_req  = i_avs_read | i_avs_write;
   wire        avs_wr   = i_avs_write & ack_ff;
   wire        avs_rd   = i_avs_read & ack_ff;
   wire [31:0] wd       = i_avs_writedata;
   wire        lane0    = i_avs_byteenable[0];
   wire        lane01   = &i_avs_byteenable[1:0];
   wire        fw_done  = avs_wr & lane01 & ~srst_ff &
                          (i_avs_address == `ATACPI_R_DONE) &
                          ((st_ff == ST_FW) | drq_ff);
   wire        fw_drq   = fw_done & wd[`ATACPI_B_DRQ];

   wire [7:0] hw_err = (op_ff == OP_BAD) ? 8'h04 :
                       ((op_ff == OP_LOCK) & locked_ff & mcr_hit) ?
                       8'h08 : 8'h00;
   wire       hw_comp = in_exec & hw_op;
   wire       comp    = hw_comp | (fw_done & ~fw_drq);
   wire [7:0] nxt_err = hw_comp ? hw_err : wd[7:0];

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff <= ST_IDLE;
         op_ff <= OP_NOP;
         cmd_ff <= 8'h00;
      end else if (srst_ff) begin
         st_ff <= ST_IDLE;
      end else begin
         unique case (st_ff)
            ST_IDLE: if (cmd_go) begin
               st_ff  <= ST_EXEC;
               cmd_ff <= dd_ff[7:0];
               op_ff  <= f_decode(dd_ff[7:0]);
            end
            ST_EXEC: st_ff <= hw_op ? ST_IDLE : ST_FW;
            ST_FW:   if (fw_done) st_ff <= ST_IDLE;
         endcase
      end
   end

   // status and error bits at completion
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         err_reg_ff <= `ATACPI_ERR_DIAG;
         err_ff     <= 1'b0;
         drq_ff     <= 1'b0;
         dout_ff    <= 1'b0;
         drdy_ff    <= 1'b0;
      end else if (srst_ff) begin
         err_reg_ff <= `ATACPI_ERR_DIAG;
         err_ff     <= 1'b0;
         drq_ff     <= 1'b0;
      end else begin
         if (cmd_go) err_ff <= 1'b0;
         if (fw_drq) begin
            drq_ff  <= 1'b1;
            dout_ff <= wd[`ATACPI_B_DOUT];
         end else if (comp) begin
            // good end clears ERR, sets DRDY
            // error end sets ERR, clears DRQ
            err_reg_ff <= nxt_err;
            err_ff     <= |nxt_err;
            drq_ff     <= 1'b0;
            drdy_ff    <= 1'b1;
         end else if (avs_wr & lane0 & (i_avs_address == `ATACPI_R_CTRL))
            drdy_ff <= wd[2];
      end
   end

   // unlock, eject and reset release it
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         locked_ff   <= 1'b0;
         mcr_seen_ff <= 1'b0;
      end else begin
         if (in_exec & (op_ff == OP_LOCK)) locked_ff <= 1'b1;
         else if (in_exec & ((op_ff == OP_UNLOCK) | (op_ff == OP_EJECT)))
            locked_ff <= 1'b0;
         if (locked_ff & btn_rise) mcr_seen_ff <= 1'b1;
         else if (cmd_go | ~locked_ff) mcr_seen_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Host registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {feat_ff, snum_ff, cyll_ff, cylh_ff, devh_ff} <= 40'h0;
         scnt_ff <= 8'h00;
         srst_ff <= 1'b0;
         nien_ff <= 1'b0;
      end else begin
         if (wr_ok & (da == `ATACPI_A_FEAT)) feat_ff <= dd_ff[7:0];
         if (wr_ok & (da == `ATACPI_A_SNUM)) snum_ff <= dd_ff[7:0];
         if (wr_ok & (da == `ATACPI_A_CYLL)) cyll_ff <= dd_ff[7:0];
         if (wr_ok & (da == `ATACPI_A_CYLH)) cylh_ff <= dd_ff[7:0];
         if (wr_ok & ~sel_ctl & (da == `ATACPI_A_DEVH))
            devh_ff <= dd_ff[7:0];
         if (in_exec & (op_ff == OP_PWR))
            scnt_ff <= ctrl_ff[0] ? `ATACPI_SC_IDLE : `ATACPI_SC_STANDBY;
         else if (wr_ok & (da == `ATACPI_A_SCNT)) scnt_ff <= dd_ff[7:0];
         if (dctl_wr) begin
            srst_ff <= dd_ff[`ATACPI_B_SRST];
            nien_ff <= dd_ff[`ATACPI_B_NIEN];
         end
      end
   end

   // status read clears pending, set wins
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) pend_ff <= 1'b0;
      else if (comp | fw_drq) pend_ff <= 1'b1;
      else if (sts_rd | srst_ff) pend_ff <= 1'b0;
   end
   assign o_intrq = pend_ff & ~nien_ff;

   // ----------------------------------------------------------------
   // PIO data path and IORDY
   // ----------------------------------------------------------------
   wire wait_w = drq_ff & (dout_ff ? hw_vld_ff : ~word_vld_ff);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         word_vld_ff  <= 1'b0;
         hw_vld_ff    <= 1'b0;
         host_word_ff <= 16'h0000;
         trd_ff       <= 4'h0;
      end else begin
         // data register takes all 16 lines
         if (data_wr) host_word_ff <= dd_ff;
         if (data_wr) hw_vld_ff <= 1'b1;
         else if (avs_rd & (i_avs_address == `ATACPI_R_DATA))
            hw_vld_ff <= 1'b0;
         if (avs_wr & lane01 & (i_avs_address == `ATACPI_R_DATA))
            word_vld_ff <= 1'b1;
         else if (data_rd | srst_ff) word_vld_ff <= 1'b0;
         // IORDY low while the device is not ready
         // data stands tRD before IORDY returns
         if (wait_w) trd_ff <= 4'h0;
         else if (trd_ff != TRD_CNT) trd_ff <= trd_ff + 4'h1;
      end
   end
   assign o_iordy = trd_ff == TRD_CNT;

   wire [15:0] rd_mux =
      sel_data                        ? word_ff :
      ctlblk                          ? {8'h00, status} :
      (da == `ATACPI_A_FEAT)          ? {8'h00, err_reg_ff} :
      (da == `ATACPI_A_SCNT)          ? {8'h00, scnt_ff} :
      (da == `ATACPI_A_SNUM)          ? {8'h00, snum_ff} :
      (da == `ATACPI_A_CYLL)          ? {8'h00, cyll_ff} :
      (da == `ATACPI_A_CYLH)          ? {8'h00, cylh_ff} :
      (da == `ATACPI_A_DEVH)          ? {8'h00, devh_ff} :
                                        {8'h00, status};

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         adr_ff    <= 5'h1f;
         dd_ff     <= 16'h0000;
         strb_ff   <= 2'h3;
         btn_ff    <= 1'b0;
         dd_out_ff <= 16'h0000;
         word_ff   <= 16'h0000;
      end else begin
         adr_ff    <= ctl_q[7:3];
         dd_ff     <= dd_q;
         strb_ff   <= {dior_n_q, diow_n_q};
         btn_ff    <= btn_q;
         dd_out_ff <= rd_mux;
         if (avs_wr & lane01 & (i_avs_address == `ATACPI_R_DATA))
            word_ff <= wd[15:0];
      end
   end
   assign o_dd    = dd_out_ff;
   assign o_dd_oe = ~dior_n_q & ~strb_ff[1] & dev_sel & (cmdblk | sel_ctl);

   // ----------------------------------------------------------------
   // Avalon registers and firmware interrupt
   // ----------------------------------------------------------------
   wire [3:0] ev = {btn_rise & ~locked_ff, data_rd, data_wr,
                    in_exec & ~hw_op};
   wire [3:0] ist_clr = (avs_wr & lane0 &
                         (i_avs_address == `ATACPI_R_ISTAT)) ?
                        wd[3:0] : 4'h0;
   wire [31:0] avs_mux =
      (i_avs_address == `ATACPI_R_CTRL)  ? {29'h0, drdy_ff, ctrl_ff} :
      (i_avs_address == `ATACPI_R_ISTAT) ? {28'h0, istat_ff} :
      (i_avs_address == `ATACPI_R_IMASK) ? {28'h0, imask_ff} :
      (i_avs_address == `ATACPI_R_CMD)   ?
         {18'h0, locked_ff, bsy, op_ff, cmd_ff} :
      (i_avs_address == `ATACPI_R_DONE)  ?
         {22'h0, dout_ff, drq_ff, err_reg_ff} :
      (i_avs_address == `ATACPI_R_DATA)  ?
         {15'h0, hw_vld_ff, host_word_ff} : 32'h0;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0;
         ctrl_ff  <= `ATACPI_RST_CTRL;
         istat_ff <= 4'h0;
         imask_ff <= 4'h0;
      end else begin
         ack_ff   <= avs_req & ~ack_ff;
         if (i_avs_read & ~ack_ff) rdata_ff <= avs_mux;
         if (avs_wr & lane0 & (i_avs_address == `ATACPI_R_CTRL))
            ctrl_ff <= wd[1:0];
         if (avs_wr & lane0 & (i_avs_address == `ATACPI_R_IMASK))
            imask_ff <= wd[3:0];
         istat_ff <= (istat_ff & ~ist_clr) | ev;
      end
   end
   assign o_avs_waitrequest = avs_req & ~ack_ff;
   assign o_avs_readdata    = rdata_ff;
   assign o_irq             = |(istat_ff & imask_ff);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_exec(atacpi_op_t o);
      in_exec && op_ff == o;
   endsequence

   a_cmd_busy_exec: assert property (
      cmd_go |=> st_ff == ST_EXEC ##1 st_ff != ST_EXEC)
      else $error("command not executed in one cycle");
   a_pwr_result: assert property (
      s_exec(OP_PWR) |=> scnt_ff ==
         ($past(ctrl_ff[0]) ? 8'hff : 8'h00))
      else $error("power query result wrong");
   a_abort_bad: assert property (
      s_exec(OP_BAD) |=> !bsy && err_ff && err_reg_ff[2])
      else $error("unknown code not aborted");
   a_lock_enter: assert property (
      s_exec(OP_LOCK) and !locked_ff |=> locked_ff && !err_ff)
      else $error("lock entry failed");
   a_lock_mcr: assert property (
      s_exec(OP_LOCK) and (locked_ff && mcr_hit)
      |=> err_ff && err_reg_ff[3] && drdy_ff)
      else $error("removal request not reported");
   a_unlock_clear: assert property (
      s_exec(OP_UNLOCK) |=> !locked_ff)
      else $error("unlock did not release");
   a_good_done: assert property (
      fw_done && !fw_drq && wd[7:0] == 8'h00
      |=> !bsy && drdy_ff && !err_ff && !drq_ff)
      else $error("good completion status wrong");
   a_err_done: assert property (
      fw_done && !fw_drq && wd[7:0] != 8'h00
      |=> !bsy && err_ff && !drq_ff && status[6])
      else $error("error completion status wrong");
   a_pend_clear: assert property (
      sts_rd && !comp && !fw_drq |=> !pend_ff)
      else $error("status read left interrupt pending");
   a_no_wait: assert property (
      !wait_w [*4] |-> o_iordy)
      else $error("IORDY low with data ready");
   a_wait_hold: assert property (
      wait_w |=> !o_iordy)
      else $error("IORDY high while not ready");
endmodule

/* File: dv/atacpi_host.sv */
// Host ATA controller model for the PIO port
// Assumes device pins sampled on i_clk
`timescale 1ns/1ps
module atacpi_host (
   // Clock and device side
   input  wire logic        i_clk,
   input  wire logic        i_iordy,
   input  wire logic [15:0] i_dd,
   // Host strobes and data
   output logic             o_cs0_n  = 1'b1,
   output logic             o_cs1_n  = 1'b1,
   output logic [2:0]       o_da     = 3'h0,
   output logic             o_dior_n = 1'b1,
   output logic             o_diow_n = 1'b1,
   output logic [15:0]      o_dd     = 16'h0
);
   task automatic cyc(input logic rd, input logic [3:0] a,
      input logic [15:0] wd, output logic [15:0] q);
      o_cs0_n <= a[3];
      o_cs1_n <= ~a[3];
      o_da <= a[2:0];
      o_dd <= rd ? ~o_dd : wd;
      @(posedge i_clk);
      o_dior_n <= ~rd;
      o_diow_n <= rd;
      repeat (8) @(posedge i_clk);
      while (i_iordy !== 1'b1) begin
         @(posedge i_clk);
      end
      q = i_dd;
      o_dior_n <= 1'b1;
      o_diow_n <= 1'b1;
      repeat (10) @(posedge i_clk);
      o_cs0_n <= 1'b1;
      o_cs1_n <= 1'b1;
      o_dd <= ~o_dd;
      @(posedge i_clk);
   endtask
endmodule

/* File: dv/atacpi_core_bench.sv */
// Bench of the ATA command core against a small model
// Assumes the host model drives the PIO pins
`timescale 1ns/1ps
module atacpi_core_bench;
   import atacpi_pkg::*;
   logic clk = 0, nrst = 0, btn = 0, rd = 0, wr = 0;
   logic [4:0] adr = 0;
   logic [31:0] wdat = 0, rdat, aq;
   logic [15:0] d_dd, h_dd, hq, w;
   logic cs0, cs1, dior, diow, oe, rdy, intrq, irq, wt;
   logic [2:0] da;
   wire logic [15:0] dd = oe ? d_dd : h_dd;
   int errors = 0, n_tests = 0, i, lk, m_lock = 0;
   logic [15:0] m_q [$];
   logic [7:0] cd [9] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'hf8, 8'hfb,
      8'hfc, 8'hec, 8'hed};
   atacpi_op_t op [9] = '{OP_READ, OP_READ, OP_WRITE, OP_WRITE,
      OP_REASGN, OP_REASGN, OP_REASGN, OP_IDENT, OP_EJECT};
   always #12.5 clk = ~clk;
   atacpi_host host (.i_clk(clk), .i_iordy(rdy), .i_dd(dd), .o_cs0_n(cs0),
      .o_cs1_n(cs1), .o_da(da), .o_dior_n(dior), .o_diow_n(diow),
      .o_dd(h_dd));
   atacpi_core dut (.i_clk(clk), .i_nrst(nrst), .i_cs0_n(cs0),
      .i_cs1_n(cs1), .i_da(da), .i_dior_n(dior), .i_diow_n(diow),
      .i_dd(dd), .o_dd(d_dd), .o_dd_oe(oe), .o_iordy(rdy),
      .o_intrq(intrq), .i_media_change_requested(btn),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_irq(irq));
   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic av(logic w1, logic [4:0] a, logic [31:0] d);
      adr <= a;
      wdat <= d;
      wr <= w1;
      rd <= ~w1;
      do begin
         @(posedge clk);
      end while (wt !== 1'b0);
      aq = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic hr(logic [2:0] a);
      host.cyc(1'b1, {1'b0, a}, 16'h0, hq);
   endtask
   task automatic cmd(logic [7:0] c);
      host.cyc(1'b0, 4'h6, 16'ha0, hq);
      host.cyc(1'b0, 4'h7, 16'(c), hq);
   endtask
   task automatic print_verdict;
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #2000000;
      errors++;
      print_verdict;
   end
   initial begin
      void'($urandom(32'hd99d));
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (5) @(posedge clk);
      hr(7); chk("status", 32'(hq[7:0]), 32'h00);
      hr(1); chk("error", 32'(hq[7:0]), 32'h01);
      chk("oe", 32'(oe), 32'h0);
      av(1, 5'h08, 32'h1);
      for (i = 0; i < 2; i++) begin
         av(1, 5'h00, i ? 32'h5 : 32'h4);
         host.cyc(1'b0, 4'h2, 16'($urandom), hq);
         cmd(8'he5);
         chk("intrq", 32'(intrq), 32'h1);
         hr(7); chk("status", 32'(hq[7:0]), 32'h40);
         chk("intrq", 32'(intrq), 32'h0);
         hr(2); chk("count", 32'(hq[7:0]), i ? 32'hff : 32'h0);
      end
      av(1, 5'h00, 32'h7);
      cmd(8'h5a);
      hr(7); chk("status", 32'(hq[7:0]), 32'h61);
      hr(1); chk("error", 32'(hq[7:0]), 32'h04);
      av(1, 5'h00, 32'h5);
      // Soft reset through the control block
      host.cyc(1'b0, 4'he, 16'h4, hq);
      hr(7); chk("busy", 32'(hq[7]), 32'h1);
      host.cyc(1'b0, 4'he, 16'h0, hq);
      hr(1); chk("error", 32'(hq[7:0]), 32'h01);
      for (lk = 0; lk < 2; lk++) begin
         btn <= lk[0];
         cmd(8'hde);
         m_lock = 1;
         hr(1); chk("error", 32'(hq[7:0]), lk ? 32'h08 : 32'h0);
         av(0, 5'h0c, 32'h0);
         chk("lock", 32'(aq[13]), 32'(m_lock));
      end
      btn <= 1'b0;
      cmd(8'hdf);
      m_lock = 0;
      av(0, 5'h0c, 32'h0);
      chk("lock", 32'(aq[13]), 32'(m_lock));
      cmd(8'hde);
      m_lock = 1;
      for (i = 0; i < 9; i++) begin
         cmd(cd[i]);
         if (cd[i] == 8'hed) m_lock = 0;
         av(0, 5'h0c, 32'h0);
         chk("op", 32'(aq[11:0]), 32'({op[i], cd[i]}));
         chk("irq", 32'(irq), 32'h1);
         if (i == 7) begin
            w = 16'($urandom);
            m_q.push_back(w);
            av(1, 5'h14, 32'(w));
            av(1, 5'h10, 32'h100);
            hr(0);
            w = m_q.pop_front();
            chk("data", 32'(hq), 32'(w));
            chk("iordy", 32'(rdy), 32'h0);
         end
         av(1, 5'h10, 32'h0);
         av(1, 5'h04, 32'hf);
         chk("irq", 32'(irq), 32'h0);
         hr(7); chk("status", 32'(hq[7:0]), 32'h40);
      end
      chk("iordy", 32'(rdy), 32'h1);
      av(0, 5'h0c, 32'h0);
      chk("lock", 32'(aq[13]), 32'(m_lock));
      print_verdict;
   end
endmodule
